/* File: hdl/anadv_pkg.sv */
// Package for the advertisement and identification register bank
package anadv_pkg;

  // ---------------------------------------------------------------
  // Register numbers on the management interface
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_ID_LOW = 5'h03;
  localparam logic [4:0] ADDR_ADV    = 5'h04;

  // ---------------------------------------------------------------
  // Advertisement field positions
  // ---------------------------------------------------------------
  localparam int BIT_NEXT_PAGE = 15;
  localparam int BIT_ACK_RSVD  = 14;
  localparam int BIT_RFAULT    = 13;
  localparam int BIT_T4        = 9;
  localparam int ABIL_LO       = 5;
  localparam int ABIL_HI       = 8;
  localparam int SEL_HI        = 4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] ADV_RESET     = 16'h01e1;
  localparam logic [3:0]  ABIL_ALL      = 4'hf;
  localparam logic [3:0]  ABIL_NONE     = 4'h0;
  localparam logic [4:0]  SEL_RESET     = 5'h01;
  // Upper six identifier bits carry part of the maker code; arbitrary
  localparam logic [5:0]  ID_OUI_RESET  = 6'h2a;
  // Model number, arbitrary value
  localparam logic [5:0]  ID_MODEL      = 6'h11;
  // Revision number, arbitrary value
  localparam logic [3:0]  ID_REV        = 4'h7;

  // Management request carrier
  typedef struct packed {
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } anadv_req_t;

  // Link code word handed to the negotiation sublayer
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } anadv_lcw_t;

endpackage

/* File: hdl/anadv_regs.sv */
// Advertisement and identification register bank of the PHY
//
// Behaviour
// R1 - Next-page bit resets zero, read/write
// R2 - Bit 14 always reads zero
// R3 - Gated writes need override control bit set
// R4 - Station writes reserved bits at defaults
// R5 - Remote-fault bit follows local link fault
// R6 - Bits 12:10 read zero, gated writes
// R7 - Ability bits advertise technology support
// R8 - T4 ability bit always reads zero
// R9 - Negotiation off: abilities undefined, use control
// R10 - Negotiation on: advertise bits 8:5, default one
// R11 - Code word sent only when negotiation enabled
// R12 - Ability default from select pin, enable
// R13 - Ability writes never change status capability
// R14 - Station restarts negotiation after ability change; the restart reloads bits 8:5 from the select pin
// R15 - Selector resets 00001, gated writes
// R16 - Identifier holds model and revision fields
// R17 - Identifier always readable, override-gated writes
// R18 - Sixteen-bit registers by register number
`timescale 1ns/1ps

module anadv_regs
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire anadv_pkg::anadv_req_t i_req,
  input  wire logic                  i_req_valid,
  input  wire logic                  i_override,
  input  wire logic                  i_an_enable,
  input  wire logic                  i_hardware_software_select_pin,
  input  wire logic                  i_local_fault,
  output logic [15:0]                o_rdata,
  output logic                       o_rvalid,
  output anadv_pkg::anadv_lcw_t      o_lcw,
  output logic [3:0]                 o_status_caps
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic        next_page_ff;
  logic [3:0]  ability_ff;
  logic [4:0]  sel_ff;
  logic [5:0]  id_oui_ff;
  logic [5:0]  id_model_ff;
  logic [3:0]  id_rev_ff;
  logic        rfault_ff;
  logic        an_en_d_ff;
  logic [15:0] nxt_rdata;
  logic [15:0] adv_word;
  logic        wr_adv;
  logic        wr_id;

  // Decode used by both write paths
  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction

  assign wr_adv = i_req_valid && i_req.wr
                  && hit(i_req.addr, anadv_pkg::ADDR_ADV);
  assign wr_id  = i_req_valid && i_req.wr
                  && hit(i_req.addr, anadv_pkg::ADDR_ID_LOW);

  // Assembled advertisement; reserved and T4 positions are constant zero
  assign adv_word = {next_page_ff, 1'b0, rfault_ff, 3'b000, 1'b0,
                     ability_ff, sel_ff};                 // see R2 R6 R8

  // ---------------------------------------------------------------
  // Next page: plain read/write
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      next_page_ff <= 1'b0;                               // see R1
    else if (wr_adv)
      next_page_ff <= i_req.wdata[anadv_pkg::BIT_NEXT_PAGE]; // see R1
  end

  // ---------------------------------------------------------------
  // Ability field: default depends on strap pin and enable
  // ---------------------------------------------------------------
  // Reloads whenever negotiation gets enabled so the default tracks
  // the mode; a station change must be followed by a restart, which reloads the default over it.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      ability_ff <= anadv_pkg::ABIL_ALL;                  // see R10
    else if (i_an_enable && !an_en_d_ff)
      ability_ff <= i_hardware_software_select_pin
                    ? anadv_pkg::ABIL_ALL
                    : anadv_pkg::ABIL_NONE;               // see R12
    else if (wr_adv && i_override)
      // see R3 R7 R14
      ability_ff <= i_req.wdata[anadv_pkg::ABIL_HI:anadv_pkg::ABIL_LO];
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      an_en_d_ff <= 1'b0;
    else
      an_en_d_ff <= i_an_enable;
  end

  // ---------------------------------------------------------------
  // Selector field, override-gated
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      sel_ff <= anadv_pkg::SEL_RESET;                     // see R15
    else if (wr_adv && i_override)
      sel_ff <= i_req.wdata[anadv_pkg::SEL_HI:0];         // see R3 R15
  end

  // ---------------------------------------------------------------
  // Remote fault tracks the local fault detector
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      rfault_ff <= 1'b0;
    else
      rfault_ff <= i_local_fault;                         // see R5
  end

  // ---------------------------------------------------------------
  // Identifier, writable only under override
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      id_oui_ff   <= anadv_pkg::ID_OUI_RESET;
      id_model_ff <= anadv_pkg::ID_MODEL;                 // see R16
      id_rev_ff   <= anadv_pkg::ID_REV;                   // see R16
    end
    else if (wr_id && i_override)
    begin
      id_oui_ff   <= i_req.wdata[15:10];                  // see R17
      id_model_ff <= i_req.wdata[9:4];
      id_rev_ff   <= i_req.wdata[3:0];
    end
  end

  // ---------------------------------------------------------------
  // Read mux; unmapped numbers return zero
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_rdata = 16'h0000;
    if (hit(i_req.addr, anadv_pkg::ADDR_ADV))
      nxt_rdata = adv_word;                               // see R18
    else if (hit(i_req.addr, anadv_pkg::ADDR_ID_LOW))
      nxt_rdata = {id_oui_ff, id_model_ff, id_rev_ff};    // see R17
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_rdata  <= 16'h0000;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rdata  <= (i_req_valid && !i_req.wr) ? nxt_rdata : o_rdata;
      o_rvalid <= i_req_valid && !i_req.wr;
    end
  end

  // ---------------------------------------------------------------
  // Link code word and fixed status capability
  // ---------------------------------------------------------------
  // With negotiation off the word is withheld; speed comes from control
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_lcw         <= '0;
      o_status_caps <= anadv_pkg::ABIL_ALL;
    end
    else
    begin
      o_lcw.valid   <= i_an_enable;                       // see R9 R11
      o_lcw.word    <= i_an_enable ? adv_word : 16'h0000; // see R11
      o_status_caps <= anadv_pkg::ABIL_ALL;               // see R13
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_gate;
    @(posedge i_clk) disable iff (!i_rst_n)
    (wr_adv && !i_override && !(i_an_enable && !an_en_d_ff))
      |=> $stable(sel_ff) && $stable(ability_ff);
  endproperty
  a_gate: assert property (p_gate) else $error("gated write took"); // see R3

  property p_rsvd;
    @(posedge i_clk) disable iff (!i_rst_n)
    // Bit 13 is the live fault flag, so only 14 and 12:9 must be zero
    o_rvalid |-> ({o_rdata[14], o_rdata[12:9]} == 5'h00
                  || $past(i_req.addr) != 5'h04);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit read one"); // see R2 R6 R8

  property p_fault;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_local_fault ##1 i_an_enable |=> o_lcw.word[13];
  endproperty
  a_fault: assert property (p_fault) else $error("fault not sent"); // see R5

  property p_np;
    @(posedge i_clk) disable iff (!i_rst_n)
    wr_adv |=> next_page_ff == $past(i_req.wdata[15]);
  endproperty
  a_np: assert property (p_np) else $error("next page not written"); // see R1

  property p_lcw;
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_an_enable |=> !o_lcw.valid && o_lcw.word == 16'h0000;
  endproperty
  a_lcw: assert property (p_lcw) else $error("word sent while off"); // see R11

  property p_caps;
    @(posedge i_clk) disable iff (!i_rst_n)
    wr_adv |=> o_status_caps == 4'hf;
  endproperty
  a_caps: assert property (p_caps) else $error("caps changed"); // see R13

  property p_id;
    @(posedge i_clk) disable iff (!i_rst_n)
    (wr_id && !i_override) |=> $stable(id_model_ff) && $stable(id_rev_ff);
  endproperty
  a_id: assert property (p_id) else $error("id changed"); // see R17

  property p_dflt;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_an_enable && !an_en_d_ff)
      |=> ability_ff == ($past(i_hardware_software_select_pin) ? 4'hf
                                                                : 4'h0);
  endproperty
  a_dflt: assert property (p_dflt) else $error("default not loaded"); // see R10 R12

endmodule

/* File: test/anadv_sta_model.sv */
// Station management model that issues register requests
`timescale 1ns/1ps

module anadv_sta_model
(
  input  wire logic            i_clk,
  output anadv_pkg::anadv_req_t o_req,
  output logic                 o_req_valid,
  output logic                 o_an_enable
);
  // ----
  // Bus cycles
  // ----
  // Idle levels from time zero
  initial
  begin
    o_req       = '0;
    o_req_valid = 1'b0;
    o_an_enable = 1'b0;
  end

  // One request pulse; reserved bits always go out at default
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [15:0] d);
    @(posedge i_clk);
    o_req       <= '{w, a, (a == anadv_pkg::ADDR_ADV) ?
                   (d & 16'ha1ff) : d};
    o_req_valid <= 1'b1;
    @(posedge i_clk);
    o_req_valid <= 1'b0;
  endtask

  // Restart so that a changed next page or selector gets used; the abilities reload from the strap pin
  task automatic restart();
    @(posedge i_clk);
    o_an_enable <= 1'b0;
    @(posedge i_clk);
    o_an_enable <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask
endmodule

/* File: test/anadv_regs_tb.sv */
// Self-checking bench for the advertisement register bank
`timescale 1ns/1ps

module anadv_regs_tb;
  logic                  i_clk;
  logic                  i_rst_n;
  anadv_pkg::anadv_req_t req;
  logic                  req_valid;
  logic                  an_en;
  logic                  ovr;
  logic                  pin;
  logic                  fault;
  logic [15:0]           o_rdata;
  logic                  o_rvalid;
  anadv_pkg::anadv_lcw_t o_lcw;
  logic [3:0]            o_status_caps;
  int                    err_count;
  int                    samples_checked;
  int                    cycles;
  logic [31:0]           seed;
  logic                  np;
  logic [3:0]            abil;
  logic [4:0]            sel;
  logic [15:0]           id_m;
  logic [15:0]           d;

  anadv_regs anadv_regs_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_req(req), .i_req_valid(req_valid), .i_override(ovr),
    .i_an_enable(an_en),
    .i_hardware_software_select_pin(pin),
    .i_local_fault(fault), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_lcw(o_lcw), .o_status_caps(o_status_caps));

  anadv_sta_model anadv_sta_model_inst (.i_clk(i_clk), .o_req(req),
    .o_req_valid(req_valid), .o_an_enable(an_en));

  // ----
  // Clock, timeout and helpers
  // ----
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // A hang counts as a failure rather than running forever
  always @(posedge i_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      err_count = err_count + 1;
      give_verdict();
    end
  end

  function automatic logic [15:0] xs16();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  // Expected advertisement word from the model state
  function automatic logic [15:0] adv_exp();
    return {np, 1'b0, fault, 4'h0, abil, sel};
  endfunction

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    anadv_sta_model_inst.xfer(1'b0, a, 16'h0000);
    #1;
    chk({16'h0000, o_rvalid}, 17'h00001);
    chk({1'b0, o_rdata}, {1'b0, exp});
  endtask

  task automatic give_verdict();
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----
  // Main sequence
  // ----
  initial
  begin
    i_rst_n = 1'b0;
    ovr = 1'b0;
    pin = 1'b1;
    fault = 1'b0;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    seed = 32'h23c0;
    np = 1'b0;
    abil = 4'hf;
    sel = 5'h01;
    id_m = {anadv_pkg::ID_OUI_RESET, anadv_pkg::ID_MODEL,
            anadv_pkg::ID_REV};
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd_chk(anadv_pkg::ADDR_ADV, adv_exp());
    rd_chk(anadv_pkg::ADDR_ID_LOW, id_m);
    rd_chk(5'h05, 16'h0000);
    chk(o_lcw, 17'h00000);
    // Strap low on restart clears every ability
    @(posedge i_clk);
    pin <= 1'b0;
    anadv_sta_model_inst.restart();
    abil = 4'h0;
    rd_chk(anadv_pkg::ADDR_ADV, adv_exp());
    // Random writes, override toggled every other one
    for (int i = 0; i < 8; i++)
    begin
      @(posedge i_clk);
      ovr <= i[0];
      d = xs16();
      anadv_sta_model_inst.xfer(1'b1, anadv_pkg::ADDR_ADV, d);
      np = d[15];
      if (i[0])
      begin
        abil = d[8:5];
        sel = d[4:0];
      end
      rd_chk(anadv_pkg::ADDR_ADV, adv_exp());
      anadv_sta_model_inst.xfer(1'b1, anadv_pkg::ADDR_ID_LOW, ~d);
      if (i[0])
        id_m = ~d;
      rd_chk(anadv_pkg::ADDR_ID_LOW, id_m);
    end
    // Fault shows in the register and in the sent word
    @(posedge i_clk);
    fault <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd_chk(anadv_pkg::ADDR_ADV, adv_exp());
    chk(o_lcw, {1'b1, adv_exp()});
    @(posedge i_clk);
    fault <= 1'b0;
    repeat (3) @(posedge i_clk);
    rd_chk(anadv_pkg::ADDR_ADV, adv_exp());
    @(posedge i_clk);
    pin <= 1'b1;
    anadv_sta_model_inst.restart();
    abil = 4'hf;
    rd_chk(anadv_pkg::ADDR_ADV, adv_exp());
    chk({13'h0000, o_status_caps}, 17'h0000f);
    give_verdict();
  end
endmodule
